// ---- rtl/rx_port_gpio_vc_map.sv ----
`timescale 1ns/1ps
`default_nettype none
module rx_port_gpio_vc_map #(
  parameter int PORTS = 4,
  parameter int LINE_W = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [PORTS*2-1:0] mode_strap,
  input wire logic [7:0] gpio_pin,
  input wire logic frame_sync_pulse,
  input wire logic [PORTS-1:0] line_total_change_irq_en,
  input wire logic [PORTS-1:0] frame_done,
  input wire logic [PORTS*LINE_W-1:0] frame_line_count,
  input wire logic [PORTS*2-1:0] pkt_vc_in,
  output logic [PORTS*4-1:0] backchannel_gpio,
  output logic [PORTS*2-1:0] pkt_vc_out,
  output logic [PORTS*6-1:0] pkt_dt_out
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [7:0] gpio_s1_q, gpio_s2_q;
  logic fs_s1_q, fs_s2_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gpio_s1_q <= 8'h00;
      gpio_s2_q <= 8'h00;
      fs_s1_q <= 1'b0;
      fs_s2_q <= 1'b0;
    end else begin
      gpio_s1_q <= gpio_pin;
      gpio_s2_q <= gpio_s1_q;
      fs_s1_q <= frame_sync_pulse;
      fs_s2_q <= fs_s1_q;
    end
  end

  // ----------------------------------------
  // strap capture after reset release
  // ----------------------------------------
  logic [PORTS*2-1:0] mode_q, mode_d;
  logic strap_done_q, strap_done_d;
  always_comb begin
    mode_d = mode_q;
    strap_done_d = 1'b1;
    if (!strap_done_q) begin
      mode_d = mode_strap;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= '0;
      strap_done_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      strap_done_q <= strap_done_d;
    end
  end

  // ----------------------------------------
  // port select and write decode
  // ----------------------------------------
  logic [1:0] port_sel_q, port_sel_d;
  always_comb begin
    port_sel_d = port_sel_q;
    if (reg_wr && reg_addr == rx_port_map_pkg::PORT_SELECT_ADDR) begin
      port_sel_d = reg_wdata[1:0];
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_sel_q <= 2'h0;
    end else begin
      port_sel_q <= port_sel_d;
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic [PORTS*8-1:0] sel_a_all, sel_b_all, ten_bit_raw_mode_all, twelve_bit_raw_mode_all, remap_all;
  // per-port copies reached through the selected port
  rx_port_bank #(.PORTS(PORTS), .RESET_VAL(rx_port_map_pkg::BC_SELECT_RESET), .ADD_PORT_VC(1'b0)) u_sel_a (
    .ref_clk(ref_clk), .rstn(rstn), .wr_port(port_sel_q), .wr_data(reg_wdata), .all_q(sel_a_all),
    .wr_en(reg_wr && hit(reg_addr, rx_port_map_pkg::BC_SELECT_A_ADDR)));
  rx_port_bank #(.PORTS(PORTS), .RESET_VAL(rx_port_map_pkg::BC_SELECT_RESET), .ADD_PORT_VC(1'b0)) u_sel_b (
    .ref_clk(ref_clk), .rstn(rstn), .wr_port(port_sel_q), .wr_data(reg_wdata), .all_q(sel_b_all),
    .wr_en(reg_wr && hit(reg_addr, rx_port_map_pkg::BC_SELECT_B_ADDR)));
  rx_port_bank #(.PORTS(PORTS), .RESET_VAL({2'b00, rx_port_map_pkg::TEN_RAW_DT_RESET}), .ADD_PORT_VC(1'b1)) u_ten_bit_raw_mode (
    .ref_clk(ref_clk), .rstn(rstn), .wr_port(port_sel_q), .wr_data(reg_wdata), .all_q(ten_bit_raw_mode_all),
    .wr_en(reg_wr && hit(reg_addr, rx_port_map_pkg::TEN_RAW_TAG_ADDR)));
  rx_port_bank #(.PORTS(PORTS), .RESET_VAL({2'b00, rx_port_map_pkg::TWELVE_RAW_DT_RESET}),
    .ADD_PORT_VC(1'b1)) u_twelve_bit_raw_mode (
    .ref_clk(ref_clk), .rstn(rstn), .wr_port(port_sel_q), .wr_data(reg_wdata), .all_q(twelve_bit_raw_mode_all),
    .wr_en(reg_wr && hit(reg_addr, rx_port_map_pkg::TWELVE_RAW_TAG_ADDR)));
  rx_port_bank #(.PORTS(PORTS), .RESET_VAL(rx_port_map_pkg::VC_REMAP_RESET), .ADD_PORT_VC(1'b0)) u_remap (
    .ref_clk(ref_clk), .rstn(rstn), .wr_port(port_sel_q), .wr_data(reg_wdata), .all_q(remap_all),
    .wr_en(reg_wr && hit(reg_addr, rx_port_map_pkg::VC_REMAP_ADDR)));

  // back-channel source decode
  function automatic logic bc_src(input logic [3:0] code, input logic [7:0] pins, input logic fs);
    if (!code[3]) begin
      bc_src = pins[code[2:0]];
    end else if (code == rx_port_map_pkg::SRC_ONE) begin
      bc_src = 1'b1;
    end else if (code == rx_port_map_pkg::SRC_FSYNC) begin
      bc_src = fs;
    end else begin
      bc_src = 1'b0;
    end
  endfunction : bc_src

  // ----------------------------------------
  // per-port datapath and line total
  // ----------------------------------------
  logic [PORTS*4-1:0] bc_q, bc_d;
  logic [PORTS*2-1:0] vc_q, vc_d;
  logic [PORTS*6-1:0] dt_q, dt_d;
  logic [PORTS*LINE_W-1:0] total_q, total_d;
  logic [PORTS-1:0] frozen_q, frozen_d;
  logic [7:0] lo_latch_q, lo_latch_d;
  logic rd_hi;
  assign rd_hi = reg_rd && hit(reg_addr, rx_port_map_pkg::LINE_TOTAL_HI_ADDR);

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    logic [15:0] sel;
    logic [7:0] r10, r12, map;
    logic [1:0] vin;
    logic [3:0] bc_n;
    assign sel = {sel_b_all[p*8 +: 8], sel_a_all[p*8 +: 8]};
    assign bc_d[p*4 +: 4] = bc_n;
    assign r10 = ten_bit_raw_mode_all[p*8 +: 8];
    assign r12 = twelve_bit_raw_mode_all[p*8 +: 8];
    assign map = remap_all[p*8 +: 8];
    assign vin = pkt_vc_in[p*2 +: 2];
    always_comb begin
      for (int b = 0; b < 4; b++) begin
        bc_n[b] = bc_src(sel[b*4 +: 4], gpio_s2_q, fs_s2_q);
      end
      unique case (rx_port_map_pkg::link_input_mode_t'(mode_q[p*2 +: 2]))
        rx_port_map_pkg::MODE_TEN_BIT_RAW_MODE: begin
          vc_d[p*2 +: 2] = r10[rx_port_map_pkg::VC_MSB:rx_port_map_pkg::VC_LSB];
          dt_d[p*6 +: 6] = r10[rx_port_map_pkg::DT_MSB:0];
        end
        rx_port_map_pkg::MODE_TWELVE_BIT_RAW_MODE_LF, rx_port_map_pkg::MODE_TWELVE_BIT_RAW_MODE_HF: begin
          vc_d[p*2 +: 2] = r12[rx_port_map_pkg::VC_MSB:rx_port_map_pkg::VC_LSB];
          dt_d[p*6 +: 6] = r12[rx_port_map_pkg::DT_MSB:0];
        end
        rx_port_map_pkg::MODE_CSI: begin
          vc_d[p*2 +: 2] = map[vin*2 +: 2];
          dt_d[p*6 +: 6] = 6'h00;
        end
      endcase
    end
    // freeze while irq enabled until host reads the upper byte
    always_comb begin
      total_d[p*LINE_W +: LINE_W] = total_q[p*LINE_W +: LINE_W];
      frozen_d[p] = frozen_q[p];
      if (rd_hi && port_sel_q == 2'(p)) begin
        frozen_d[p] = 1'b0;
      end
      // a frame in the cycle of the releasing read is taken and freezes again
      if (frame_done[p] && (!(frozen_q[p] && line_total_change_irq_en[p]) || (rd_hi && port_sel_q == 2'(p)))) begin
        total_d[p*LINE_W +: LINE_W] = frame_line_count[p*LINE_W +: LINE_W];
        frozen_d[p] = line_total_change_irq_en[p];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bc_q <= '0;
      vc_q <= '0;
      dt_q <= '0;
      total_q <= '0;
      frozen_q <= '0;
      lo_latch_q <= 8'h00;
    end else begin
      bc_q <= bc_d;
      vc_q <= vc_d;
      dt_q <= dt_d;
      total_q <= total_d;
      frozen_q <= frozen_d;
      lo_latch_q <= lo_latch_d;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [7:0] rdata_q, rdata_d;
  logic [LINE_W-1:0] cur_total;
  assign cur_total = total_q[port_sel_q*LINE_W +: LINE_W];
  always_comb begin
    lo_latch_d = lo_latch_q;
    rdata_d = rdata_q;
    if (rd_hi) begin
      lo_latch_d = cur_total[7:0];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        rx_port_map_pkg::PORT_SELECT_ADDR: rdata_d = {6'h00, port_sel_q};
        rx_port_map_pkg::BC_SELECT_A_ADDR: rdata_d = sel_a_all[port_sel_q*8 +: 8];
        rx_port_map_pkg::BC_SELECT_B_ADDR: rdata_d = sel_b_all[port_sel_q*8 +: 8];
        rx_port_map_pkg::TEN_RAW_TAG_ADDR: rdata_d = ten_bit_raw_mode_all[port_sel_q*8 +: 8];
        rx_port_map_pkg::TWELVE_RAW_TAG_ADDR: rdata_d = twelve_bit_raw_mode_all[port_sel_q*8 +: 8];
        rx_port_map_pkg::VC_REMAP_ADDR: rdata_d = remap_all[port_sel_q*8 +: 8];
        rx_port_map_pkg::LINE_TOTAL_HI_ADDR: rdata_d = cur_total[15:8];
        rx_port_map_pkg::LINE_TOTAL_LO_ADDR: rdata_d = lo_latch_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign backchannel_gpio = bc_q;
  assign pkt_vc_out = vc_q;
  assign pkt_dt_out = dt_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_bc_reset_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    (sel_a_all[3:0] == rx_port_map_pkg::SRC_ZERO) |=> (backchannel_gpio[0] == 1'b0))
    else $error("back-channel bit not zero for constant-zero code");
  a_bc_one_const: assert property (@(posedge ref_clk) disable iff (!rstn)
    (sel_a_all[3:0] == rx_port_map_pkg::SRC_ONE) |=> backchannel_gpio[0])
    else $error("back-channel bit not one for constant-one code");
  a_bc_pin_fwd: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!sel_a_all[3]) |=> (backchannel_gpio[0] == $past(gpio_s2_q[sel_a_all[2:0]])))
    else $error("back-channel bit does not follow selected pin");
  a_ten_bit_raw_channel_tag: assert property (@(posedge ref_clk) disable iff (!rstn)
    (strap_done_q && mode_q[7:6] == 2'h3) |=> (pkt_vc_out[7:6] == $past(ten_bit_raw_mode_all[31:30])))
    else $error("ten-bit raw channel tag wrong");
  a_twelve_bit_raw_datatype_tag: assert property (@(posedge ref_clk) disable iff (!rstn)
    (strap_done_q && mode_q[3:2] == 2'h1) |=> (pkt_dt_out[11:6] == $past(twelve_bit_raw_mode_all[13:8])))
    else $error("twelve-bit raw data type wrong");
  a_csi_remap: assert property (@(posedge ref_clk) disable iff (!rstn)
    (strap_done_q && mode_q[1:0] == 2'h0 && remap_all[7:0] == 8'hE4) |=> (pkt_vc_out[1:0] == $past(pkt_vc_in[1:0])))
    else $error("identity remap altered channel");
  a_total_frozen: assert property (@(posedge ref_clk) disable iff (!rstn)
    (frozen_q[1] && line_total_change_irq_en[1] && !(rd_hi && port_sel_q == 2'h1)) |=>
    $stable(total_q[2*LINE_W-1:LINE_W]))
    else $error("frozen line total changed");
  a_lo_latched: assert property (@(posedge ref_clk) disable iff (!rstn)
    rd_hi |=> (lo_latch_q == $past(cur_total[7:0])))
    else $error("lower line byte not latched on upper read");
endmodule : rx_port_gpio_vc_map
`default_nettype wire

// ---- rtl/rx_port_map_pkg.sv ----
package rx_port_map_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] PORT_SELECT_ADDR = 8'h4C;
  localparam logic [7:0] BC_SELECT_A_ADDR = 8'h6E;
  localparam logic [7:0] BC_SELECT_B_ADDR = 8'h6F;
  localparam logic [7:0] TEN_RAW_TAG_ADDR = 8'h70;
  localparam logic [7:0] TWELVE_RAW_TAG_ADDR = 8'h71;
  localparam logic [7:0] VC_REMAP_ADDR = 8'h72;
  localparam logic [7:0] LINE_TOTAL_HI_ADDR = 8'h73;
  localparam logic [7:0] LINE_TOTAL_LO_ADDR = 8'h74;
  // ----------------------------------------
  // reset values and fields
  // ----------------------------------------
  localparam logic [7:0] BC_SELECT_RESET = 8'h88;
  localparam logic [5:0] TEN_RAW_DT_RESET = 6'h2B;
  localparam logic [5:0] TWELVE_RAW_DT_RESET = 6'h2C;
  localparam logic [7:0] VC_REMAP_RESET = 8'hE4;
  localparam int VC_MSB = 7;
  localparam int VC_LSB = 6;
  localparam int DT_MSB = 5;
  // ----------------------------------------
  // back-channel select codes
  // ----------------------------------------
  localparam logic [3:0] SRC_ZERO = 4'h8;
  localparam logic [3:0] SRC_ONE = 4'h9;
  localparam logic [3:0] SRC_FSYNC = 4'hA;
  // ----------------------------------------
  // input modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_CSI = 2'h0,
    MODE_TWELVE_BIT_RAW_MODE_LF = 2'h1,
    MODE_TWELVE_BIT_RAW_MODE_HF = 2'h2,
    MODE_TEN_BIT_RAW_MODE = 2'h3
  } link_input_mode_t;
endpackage : rx_port_map_pkg

// ---- rtl/rx_port_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
// per-port storage of one writable register, every copy driven straight out on all_q
module rx_port_bank #(
  parameter int PORTS = 4,
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter bit ADD_PORT_VC = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [1:0] wr_port,
  input wire logic [7:0] wr_data,
  output logic [PORTS*8-1:0] all_q
);
  logic [PORTS*8-1:0] mem_q, mem_d;
  // --------------------------------
  // write next value
  // --------------------------------
  always_comb begin
    mem_d = mem_q;
    if (wr_en) begin
      mem_d[wr_port*8 +: 8] = wr_data;
    end
  end
  // per-port reset, optionally carrying the port number as channel
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < PORTS; i++) begin
        mem_q[i*8 +: 8] <= ADD_PORT_VC ? (RESET_VAL | 8'(i << 6)) : RESET_VAL;
      end
    end else begin
      mem_q <= mem_d;
    end
  end
  assign all_q = mem_q;
endmodule : rx_port_bank
`default_nettype wire

// ---- test/remote_serializer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// far-side serializer: sends packet channel ids, receives back-channel bits
module remote_serializer_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [15:0] backchannel_gpio,
  input wire logic [7:0] vc_plan,
  output logic [7:0] pkt_vc_in,
  output logic [15:0] bc_seen
);
  // ----------------------------------------
  // forward packets and back channel
  // ----------------------------------------
  // channel ids change off the hub's sampling edge
  always @(negedge ref_clk or negedge rstn) begin
    if (!rstn) pkt_vc_in <= 8'h00;
    else pkt_vc_in <= vc_plan;
  end
  // back-channel bits as the serializer receives them
  always @(posedge ref_clk) begin
    bc_seen <= backchannel_gpio;
  end
endmodule : remote_serializer_model
`default_nettype wire

// ---- test/test_rx_port_gpio_vc_map.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_rx_port_gpio_vc_map;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, frame_sync_pulse = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, gpio_pin = 8'h00, vc_plan = 8'h00;
  logic [7:0] mode_strap = 8'hE4; // port0 csi, port1/2 twelve-bit, port3 ten-bit
  logic [3:0] irq_en = 4'h0, frame_done = 4'h0;
  logic [63:0] line_cnt = 64'h0;
  logic [7:0] reg_rdata, pkt_vc_in, pkt_vc_out;
  logic [15:0] backchannel_gpio, bc_seen;
  logic [23:0] pkt_dt_out;
  logic [7:0] sh [4][5]; // shadow of 0x6E..0x72 per port
  logic [31:0] rnd = 32'hB408;
  int errors = 0, num_checks = 0;
  always #25 ref_clk = ~ref_clk;
  rx_port_gpio_vc_map #(.PORTS(4), .LINE_W(16)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mode_strap(mode_strap),
    .gpio_pin(gpio_pin), .frame_sync_pulse(frame_sync_pulse), .line_total_change_irq_en(irq_en),
    .frame_done(frame_done), .frame_line_count(line_cnt), .pkt_vc_in(pkt_vc_in),
    .backchannel_gpio(backchannel_gpio), .pkt_vc_out(pkt_vc_out), .pkt_dt_out(pkt_dt_out));
  remote_serializer_model far_u (.ref_clk(ref_clk), .rstn(rstn), .backchannel_gpio(backchannel_gpio),
    .vc_plan(vc_plan), .pkt_vc_in(pkt_vc_in), .bc_seen(bc_seen));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  function automatic logic [7:0] bc_exp(input logic [3:0] c);
    if (!c[3]) return {7'h00, gpio_pin[c[2:0]]};
    if (c == 4'h9) return 8'h01;
    if (c == 4'hA) return {7'h00, frame_sync_pulse};
    return 8'h00; // zero, reserved codes too
  endfunction : bc_exp
  function automatic logic [7:0] vc_exp(input int p);
    case (mode_strap[2*p+:2])
      2'h0: return {6'h00, sh[p][4][2*pkt_vc_in[2*p+:2]+:2]};
      2'h3: return {6'h00, sh[p][2][7:6]};
      default: return {6'h00, sh[p][3][7:6]};
    endcase
  endfunction : vc_exp
  function automatic logic [7:0] dt_exp(input int p);
    case (mode_strap[2*p+:2])
      2'h0: return 8'h00;
      2'h3: return {2'h0, sh[p][2][5:0]};
      default: return {2'h0, sh[p][3][5:0]};
    endcase
  endfunction : dt_exp
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, e);
  endtask : rdx
  task automatic frame(input int p, input logic [15:0] n);
    @(negedge ref_clk);
    frame_done[p] = 1'b1;
    line_cnt[16*p+:16] = n;
    @(negedge ref_clk);
    frame_done = 4'h0;
  endtask : frame
  task automatic check_port(input int p);
    for (int b = 0; b < 4; b++) chk({7'h00, bc_seen[4*p+b]}, bc_exp(sh[p][b/2][4*(b%2)+:4]));
    chk({6'h00, pkt_vc_out[2*p+:2]}, vc_exp(p));
    chk({2'h0, pkt_dt_out[6*p+:6]}, dt_exp(p));
  endtask : check_port
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    complete_run;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] v;
    int p;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) rstn = 1'b1;
    for (int q = 0; q < 4; q++) begin
      sh[q] = '{8'h88, 8'h88, {q[1:0], 6'h2B}, {q[1:0], 6'h2C}, 8'hE4};
    end
    repeat (6) @(negedge ref_clk);
    // reset values of every port's copy
    for (int q = 0; q < 4; q++) begin
      check_port(q);
      wr(8'h4C, q[7:0]);
      for (int r = 0; r < 5; r++) rdx(8'h6E + r[7:0], sh[q][r]);
      rdx(8'h73, 8'h00);
    end
    wr(8'h73, 8'hFF);
    rdx(8'h73, 8'h00);
    rdx(8'h60, 8'h00);
    // random programming, first sixteen walk every select code
    for (int i = 0; i < 48; i++) begin
      rnd = xs(rnd);
      p = int'(rnd[1:0]);
      wr(8'h4C, rnd[7:0] & 8'h03);
      for (int r = 0; r < 5; r++) begin
        rnd = xs(rnd);
        v = rnd[7:0];
        if (r == 0 && i < 16) v[3:0] = i[3:0];
        sh[p][r] = v;
        wr(8'h6E + r[7:0], v);
      end
      rnd = xs(rnd);
      gpio_pin = rnd[7:0];
      frame_sync_pulse = rnd[8];
      vc_plan = rnd[23:16];
      repeat (6) @(negedge ref_clk);
      rdx(8'h6E + 8'(i % 5), sh[p][i % 5]);
      for (int q = 0; q < 4; q++) check_port(q);
    end
    // line total: freeze, latch of low byte, other port
    irq_en = 4'h2;
    wr(8'h4C, 8'h01);
    rdx(8'h73, 8'h00);
    frame(1, 16'h1234);
    frame(1, 16'h5678);
    frame(0, 16'h9ABC);
    rdx(8'h73, 8'h12);
    rdx(8'h74, 8'h34);
    frame(1, 16'hA55A);
    rdx(8'h73, 8'hA5);
    frame(1, 16'h0F0F);
    rdx(8'h74, 8'h5A);
    irq_en = 4'h0;
    frame(1, 16'h3C3C);
    rdx(8'h73, 8'h3C);
    wr(8'h4C, 8'h00);
    rdx(8'h73, 8'h9A);
    complete_run;
  end
endmodule : test_rx_port_gpio_vc_map
`default_nettype wire
